// ### rtl/sqp_pkg.sv
// shared constants and instruction decode for the serial quad host port
package sqp_pkg;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_DUAL_DATA_WRITE = 8'h32;
   localparam logic [7:0] OP_QUAD_DATA_WRITE = 8'h62;
   localparam logic [7:0] OP_DUAL_ADDR_DATA_WRITE = 8'hb2;
   localparam logic [7:0] OP_QUAD_ADDR_DATA_WRITE = 8'he2;
   localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
   localparam logic [7:0] OP_LEAVE_QUAD_MODE = 8'hff;
   localparam logic [1:0] ADDR_AUTO_INC = 2'h1;
   localparam logic [1:0] ADDR_AUTO_DEC = 2'h2;
   localparam logic [5:0] CMD_BITS = 6'h08;
   localparam logic [5:0] ADDR_BITS = 6'h10;
   localparam logic [5:0] WORD_BITS = 6'h20;
   localparam int DUMMY_BYTES = 4;
   localparam logic [5:0] DUMMY_BITS = 6'(DUMMY_BYTES * 8);
   localparam int CLK_PERIOD_NS = 4;
   localparam int SCK_MAX_READ_MHZ = 30;
   localparam int SCK_MAX_MHZ = 80;
   localparam int SCK_PERIOD_NS = 48;
   localparam int SCK_HALF_CYC = (SCK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CS_IDLE_NS = 50;
   localparam int CS_IDLE_CYC = (CS_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // lines per clock for address bytes; zero means not accepted in this mode
   function automatic logic [2:0] sqp_addr_w(input logic [7:0] op, input logic quad);
      logic [2:0] w;
      w = 3'd0;
      if (quad)
         w = (op == OP_WRITE) ? 3'd4 : 3'd0;
      else if (op == OP_WRITE || op == OP_DUAL_DATA_WRITE || op == OP_QUAD_DATA_WRITE)
         w = 3'd1;
      else if (op == OP_DUAL_ADDR_DATA_WRITE)
         w = 3'd2;
      else if (op == OP_QUAD_ADDR_DATA_WRITE || op == OP_QUAD_IO_READ)
         w = 3'd4;
      return w;
   endfunction : sqp_addr_w

   // lines per clock for the data words
   function automatic logic [2:0] sqp_data_w(input logic [7:0] op, input logic quad);
      logic [2:0] w;
      w = 3'd4;
      if (op == OP_WRITE)
         w = quad ? 3'd4 : 3'd1;
      else if (op == OP_DUAL_DATA_WRITE || op == OP_DUAL_ADDR_DATA_WRITE)
         w = 3'd2;
      return w;
   endfunction : sqp_data_w

   // wire order is lowest byte first, msb first within each byte
   function automatic logic [31:0] sqp_bswap(input logic [31:0] d);
      return {d[7:0], d[15:8], d[23:16], d[31:24]};
   endfunction : sqp_bswap
endpackage : sqp_pkg

// ### rtl/sqp_if.sv
// link wires between host controller and device port
`timescale 1ns/10ps
`default_nettype none
interface sqp_if;
   logic sck;
   logic host_port_select_n;
   logic [3:0] host_dq;
   logic [3:0] host_oe;
   logic [3:0] dev_dq;
   logic [3:0] dev_oe;
   logic [3:0] host_data_lines;

   // undriven lines float high as through a weak pull-up
   assign host_data_lines = (host_oe & host_dq) | (dev_oe & dev_dq) | ~(host_oe | dev_oe);

   modport host (output sck, output host_port_select_n, output host_dq, output host_oe,
      input host_data_lines);
   modport dev (input sck, input host_port_select_n, input host_data_lines,
      output dev_dq, output dev_oe);
endinterface : sqp_if
`default_nettype wire

// ### rtl/sqp_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module sqp_sync
#(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
)
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         meta_reg <= INIT;
         sync_reg <= INIT;
      end
      else
      begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end

   assign q_o = sync_reg;
endmodule : sqp_sync
`default_nettype wire

// ### rtl/sqp_dev.sv
// device end: instruction decode, shifting, register write and read strobes
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - host frames each transfer with select low
// - quad read: code serial, address+dummy nibble-wide
// - read nibbles driven on falling edges, lowest byte first, msn first
// - data lines released when select rises
// - multi-line codes refused in quad instruction mode
// - address bits 15:14 pick increment, decrement, hold
// - basic write serial or nibble-wide per mode
// - write data lowest byte first, msb first
// - register written only after 32 data bits
// - dual data write: data on two lines
// - quad data write: data on four lines
// - dual address and data write on two lines
// - quad address and data write on four lines
// - status FIFO normal address read pops
// - status FIFO peek address read never pops
// - host clock limits 30 and 80 MHz
// - host may sample read data late
// - leave code returns to single-line at deselect
// - read side effect taken when shifting starts
module sqp_dev
   import sqp_pkg::*;
#(
   parameter int DWA_W = 12,
   parameter logic [DWA_W-1:0] TXS_FIFO_ADDR = 12'h010,
   parameter logic [DWA_W-1:0] RXS_FIFO_ADDR = 12'h011
)
(
   input wire logic clk_i,
   input wire logic rstn_i,
   sqp_if.dev link,
   input wire logic enter_quad_i,
   output logic quad_mode_o,
   output logic wr_o,
   output logic [DWA_W-1:0] wr_addr_o,
   output logic [31:0] wr_data_o,
   output logic rd_o,
   output logic rd_pop_o,
   output logic [DWA_W-1:0] rd_addr_o,
   input wire logic [31:0] rd_data_i
);
   typedef enum logic [2:0] {
      D_IDLE = 3'b000,
      D_CMD = 3'b001,
      D_ADDR = 3'b011,
      D_DUMMY = 3'b010,
      D_RDATA = 3'b110,
      D_WDATA = 3'b111,
      D_IGNORE = 3'b101
   } sqp_dstate_t;

   sqp_dstate_t st_reg;
   logic [5:0] pins_s;
   logic cs_n_s, sck_s, sck_prev_reg, rise, fall;
   logic [3:0] din_s;
   logic [2:0] wid_reg, aw_in;
   logic [5:0] cnt_reg, cnt_in;
   logic [31:0] sh_reg, sh_in, osh_reg, rd_word;
   logic [7:0] op_reg, op_in;
   logic quad_reg, quadtx_reg, leave_reg, cmd_done;
   logic [1:0] mode_reg;
   logic [DWA_W-1:0] dwa_reg;
   logic wr_go, rd_go, wr_reg;
   logic [DWA_W-1:0] wr_addr_reg;
   logic [31:0] wr_data_reg;
   logic [3:0] dq_reg, oe_reg;
   logic [2:0] ocnt_reg;

   function automatic logic [DWA_W-1:0] step(input logic [DWA_W-1:0] a, input logic [1:0] m);
      logic [DWA_W-1:0] r;
      r = a;
      if (m == ADDR_AUTO_INC)
         r = a + 1'b1;
      else if (m == ADDR_AUTO_DEC)
         r = a - 1'b1;
      return r;
   endfunction : step

   sqp_sync #(.W(6), .INIT(6'h20)) u_sync (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .d_i({link.host_port_select_n, link.sck, link.host_data_lines}),
      .q_o(pins_s)
   );
   assign {cs_n_s, sck_s, din_s} = pins_s;

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
         sck_prev_reg <= 1'b0;
      else
         sck_prev_reg <= sck_s;
   end

   // edges only count while selected
   assign rise = ~cs_n_s & sck_s & ~sck_prev_reg;
   assign fall = ~cs_n_s & ~sck_s & sck_prev_reg;

   always_comb
   begin
      unique case (wid_reg)
         3'd2: sh_in = {sh_reg[29:0], din_s[1:0]};
         3'd4: sh_in = {sh_reg[27:0], din_s};
         default: sh_in = {sh_reg[30:0], din_s[0]};
      endcase
   end

   assign cnt_in = cnt_reg + {3'h0, wid_reg};
   assign op_in = sh_in[7:0];
   assign aw_in = sqp_addr_w(op_in, quadtx_reg);
   assign cmd_done = rise && st_reg == D_CMD && cnt_in == CMD_BITS;
   assign wr_go = rise && st_reg == D_WDATA && cnt_in == WORD_BITS;
   assign rd_go = fall && st_reg == D_RDATA && ocnt_reg == 3'd0;

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         st_reg <= D_IDLE;
         wid_reg <= 3'd1;
         cnt_reg <= '0;
         sh_reg <= '0;
         op_reg <= '0;
         quadtx_reg <= 1'b0;
      end
      else if (cs_n_s)
      begin
         // a word cut short by deselect is simply dropped
         st_reg <= D_IDLE;
         cnt_reg <= '0;
         sh_reg <= '0;
      end
      else if (st_reg == D_IDLE)
      begin
         st_reg <= D_CMD;
         quadtx_reg <= quad_reg;
         wid_reg <= quad_reg ? 3'd4 : 3'd1;
         cnt_reg <= '0;
      end
      else if (rise)
      begin
         sh_reg <= sh_in;
         cnt_reg <= cnt_in;
         unique case (st_reg)
            D_CMD:
               if (cnt_in == CMD_BITS)
               begin
                  op_reg <= op_in;
                  cnt_reg <= '0;
                  if (aw_in != 3'd0)
                  begin
                     st_reg <= D_ADDR;
                     wid_reg <= aw_in;
                  end
                  else
                     st_reg <= D_IGNORE;
               end
            D_ADDR:
               if (cnt_in == ADDR_BITS)
               begin
                  cnt_reg <= '0;
                  if (op_reg == OP_QUAD_IO_READ)
                  begin
                     st_reg <= D_DUMMY;
                     wid_reg <= 3'd4;
                  end
                  else
                  begin
                     st_reg <= D_WDATA;
                     wid_reg <= sqp_data_w(op_reg, quadtx_reg);
                  end
               end
            D_DUMMY:
               if (cnt_in == DUMMY_BITS)
                  st_reg <= D_RDATA;
            D_WDATA:
               if (cnt_in == WORD_BITS)
                  cnt_reg <= '0;
            default:
               ;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         mode_reg <= 2'h0;
         dwa_reg <= '0;
      end
      else if (rise && st_reg == D_ADDR && cnt_in == ADDR_BITS)
      begin
         mode_reg <= sh_in[15:14];
         dwa_reg <= sh_in[DWA_W+1:2];
      end
      else if (wr_go || rd_go)
         dwa_reg <= step(dwa_reg, mode_reg);
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         wr_reg <= 1'b0;
         wr_addr_reg <= '0;
         wr_data_reg <= '0;
      end
      else
      begin
         wr_reg <= wr_go;
         if (wr_go)
         begin
            wr_addr_reg <= dwa_reg;
            wr_data_reg <= sqp_bswap(sh_in);
         end
      end
   end

   // the fetch is the start of the shift, so pops are never deferred
   assign rd_o = rd_go;
   assign rd_addr_o = dwa_reg;
   assign rd_pop_o = rd_go && (dwa_reg == TXS_FIFO_ADDR || dwa_reg == RXS_FIFO_ADDR);
   assign rd_word = sqp_bswap(rd_data_i);

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i || cs_n_s)
      begin
         oe_reg <= 4'h0;
         dq_reg <= 4'h0;
         osh_reg <= '0;
         ocnt_reg <= 3'd0;
      end
      else if (fall && st_reg == D_RDATA)
      begin
         oe_reg <= 4'hf;
         ocnt_reg <= ocnt_reg + 3'd1;
         if (ocnt_reg == 3'd0)
         begin
            dq_reg <= rd_word[31:28];
            osh_reg <= {rd_word[27:0], 4'h0};
         end
         else
         begin
            dq_reg <= osh_reg[31:28];
            osh_reg <= {osh_reg[27:0], 4'h0};
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         quad_reg <= 1'b0;
         leave_reg <= 1'b0;
      end
      else
      begin
         if (cs_n_s)
            leave_reg <= 1'b0;
         else if (cmd_done && op_in == OP_LEAVE_QUAD_MODE)
            leave_reg <= 1'b1;
         // entry request wins over a pending leave
         if (enter_quad_i)
            quad_reg <= 1'b1;
         else if (cs_n_s && leave_reg)
            quad_reg <= 1'b0;
      end
   end

   assign quad_mode_o = quad_reg;
   assign wr_o = wr_reg;
   assign wr_addr_o = wr_addr_reg;
   assign wr_data_o = wr_data_reg;
   assign link.dev_dq = dq_reg;
   assign link.dev_oe = oe_reg;
endmodule : sqp_dev
`default_nettype wire

// ### rtl/sqp_host.sv
// host end: makes the serial clock and shifts one command per select frame
`timescale 1ns/10ps
`default_nettype none
module sqp_host
   import sqp_pkg::*;
#(
   parameter int HALF_CYC = SCK_HALF_CYC,
   parameter int GAP_CYC = CS_IDLE_CYC
)
(
   input wire logic clk_i,
   input wire logic rstn_i,
   sqp_if.host link,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic [7:0] cmd_op_i,
   input wire logic [15:0] cmd_addr_i,
   input wire logic [31:0] cmd_wdata_i,
   input wire logic [3:0] cmd_words_i,
   input wire logic quad_mode_i,
   output logic [31:0] rdata_o,
   output logic rdata_valid_o,
   output logic done_o
);
   typedef enum logic [1:0] {H_IDLE = 2'b00, H_RUN = 2'b01, H_GAP = 2'b11} sqp_hstate_t;
   typedef enum logic [1:0] {P_CMD = 2'b00, P_ADDR = 2'b01, P_DUMMY = 2'b11, P_DATA = 2'b10} sqp_phase_t;

   sqp_hstate_t st_reg;
   sqp_phase_t ph_reg, ph_next;
   logic [7:0] op_reg, div_reg, gap_reg;
   logic [15:0] addr_reg;
   logic [31:0] wdata_reg, tx_reg, tx_next, rx_reg, rdata_reg;
   logic [3:0] words_reg, dq_reg, oe_reg, din_s;
   logic quad_reg, sck_reg, cs_n_reg, tick, rise_t, fall_t, rd_op, last, rvalid_reg, done_reg;
   logic [2:0] w_reg, w_next, aw, dw, cw, nib_reg;
   logic [5:0] left_reg, left_next;

   function automatic logic [5:0] clks(input logic [5:0] bits, input logic [2:0] w);
      return (w == 3'd4) ? bits >> 2 : (w == 3'd2) ? bits >> 1 : bits;
   endfunction : clks

   function automatic logic [3:0] pres(input logic [31:0] t, input logic [2:0] w);
      return (w == 3'd4) ? t[31:28] : (w == 3'd2) ? {2'h0, t[31:30]} : {3'h0, t[31]};
   endfunction : pres

   function automatic logic [3:0] lmask(input logic [2:0] w);
      return (w == 3'd4) ? 4'hf : (w == 3'd2) ? 4'h3 : 4'h1;
   endfunction : lmask

   sqp_sync #(.W(4), .INIT(4'hf)) u_sync (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .d_i(link.host_data_lines),
      .q_o(din_s)
   );

   // half period fixed well below 30 MHz so every code is legal
   assign tick = st_reg == H_RUN && div_reg == 8'h00;
   assign rise_t = tick & ~sck_reg;
   assign fall_t = tick & sck_reg;
   assign cw = quad_mode_i ? 3'd4 : 3'd1;
   assign aw = sqp_addr_w(op_reg, quad_reg);
   assign dw = sqp_data_w(op_reg, quad_reg);
   assign rd_op = op_reg == OP_QUAD_IO_READ;

   always_comb
   begin
      ph_next = ph_reg;
      w_next = w_reg;
      left_next = '0;
      tx_next = '0;
      last = 1'b0;
      unique case (ph_reg)
         P_CMD:
            if (aw == 3'd0)
               last = 1'b1;
            else
            begin
               ph_next = P_ADDR;
               w_next = aw;
               left_next = clks(ADDR_BITS, aw);
               tx_next = {addr_reg, 16'h0};
            end
         P_ADDR:
            if (rd_op)
            begin
               ph_next = P_DUMMY;
               w_next = 3'd4;
               left_next = clks(DUMMY_BITS, 3'd4);
            end
            else
            begin
               ph_next = P_DATA;
               w_next = dw;
               left_next = clks(WORD_BITS, dw);
               tx_next = sqp_bswap(wdata_reg);
            end
         P_DUMMY:
         begin
            ph_next = P_DATA;
            w_next = 3'd4;
            left_next = clks(WORD_BITS, 3'd4);
         end
         P_DATA:
            if (words_reg <= 4'h1)
               last = 1'b1;
            else
            begin
               left_next = clks(WORD_BITS, w_reg);
               tx_next = sqp_bswap(wdata_reg);
            end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         op_reg <= '0;
         addr_reg <= '0;
         wdata_reg <= '0;
         quad_reg <= 1'b0;
      end
      else if (st_reg == H_IDLE && cmd_valid_i)
      begin
         op_reg <= cmd_op_i;
         addr_reg <= cmd_addr_i;
         wdata_reg <= cmd_wdata_i;
         quad_reg <= quad_mode_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         st_reg <= H_IDLE;
         ph_reg <= P_CMD;
         cs_n_reg <= 1'b1;
         sck_reg <= 1'b0;
         div_reg <= '0;
         gap_reg <= '0;
         w_reg <= 3'd1;
         left_reg <= '0;
         tx_reg <= '0;
         dq_reg <= '0;
         oe_reg <= '0;
         words_reg <= '0;
         done_reg <= 1'b0;
      end
      else
      begin
         done_reg <= 1'b0;
         unique case (st_reg)
            H_IDLE:
               if (cmd_valid_i)
               begin
                  st_reg <= H_RUN;
                  cs_n_reg <= 1'b0;
                  ph_reg <= P_CMD;
                  w_reg <= cw;
                  left_reg <= clks(CMD_BITS, cw);
                  tx_reg <= {cmd_op_i, 24'h0};
                  dq_reg <= pres({cmd_op_i, 24'h0}, cw);
                  oe_reg <= lmask(cw);
                  div_reg <= 8'(HALF_CYC - 1);
                  words_reg <= cmd_words_i;
               end
            H_RUN:
            begin
               div_reg <= (div_reg == 8'h00) ? 8'(HALF_CYC - 1) : div_reg - 8'h01;
               if (tick)
                  sck_reg <= ~sck_reg;
               if (rise_t)
                  left_reg <= left_reg - 6'h01;
               if (fall_t && left_reg != 6'h00)
               begin
                  tx_reg <= tx_reg << w_reg;
                  dq_reg <= pres(tx_reg << w_reg, w_reg);
               end
               else if (fall_t && last)
               begin
                  st_reg <= H_GAP;
                  cs_n_reg <= 1'b1;
                  oe_reg <= 4'h0;
                  gap_reg <= 8'(GAP_CYC - 1);
                  done_reg <= 1'b1;
               end
               else if (fall_t)
               begin
                  ph_reg <= ph_next;
                  w_reg <= w_next;
                  left_reg <= left_next;
                  tx_reg <= tx_next;
                  dq_reg <= pres(tx_next, w_next);
                  // hand the lines to the device for read data
                  oe_reg <= (rd_op && ph_next == P_DATA) ? 4'h0 : lmask(w_next);
                  if (ph_reg == P_DATA)
                     words_reg <= words_reg - 4'h1;
               end
            end
            H_GAP:
               if (gap_reg == 8'h00)
                  st_reg <= H_IDLE;
               else
                  gap_reg <= gap_reg - 8'h01;
            default:
               st_reg <= H_IDLE;
         endcase
      end
   end

   // sampling on the falling edge leaves a full period for output valid time
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         rx_reg <= '0;
         nib_reg <= 3'd0;
         rdata_reg <= '0;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         rvalid_reg <= 1'b0;
         if (fall_t && rd_op && ph_reg == P_DATA)
         begin
            rx_reg <= {rx_reg[27:0], din_s};
            nib_reg <= nib_reg + 3'd1;
            if (nib_reg == 3'd7)
            begin
               rdata_reg <= sqp_bswap({rx_reg[27:0], din_s});
               rvalid_reg <= 1'b1;
            end
         end
      end
   end

   assign cmd_ready_o = st_reg == H_IDLE;
   assign rdata_o = rdata_reg;
   assign rdata_valid_o = rvalid_reg;
   assign done_o = done_reg;
   assign link.sck = sck_reg;
   assign link.host_port_select_n = cs_n_reg;
   assign link.host_dq = dq_reg;
   assign link.host_oe = oe_reg;
endmodule : sqp_host
`default_nettype wire

// ### tb/sqp_assertions.sv
// link protocol checker for the serial quad host port
`timescale 1ns/10ps
`default_nettype none
module sqp_assertions
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic sck,
   input wire logic host_port_select_n,
   input wire logic [3:0] host_dq,
   input wire logic [3:0] host_oe,
   input wire logic [3:0] dev_dq,
   input wire logic [3:0] dev_oe
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   property p_idle_clk;
      host_port_select_n |-> !sck;
   endproperty
   a_idle_clk: assert property (p_idle_clk) else $error("sck high outside a frame");
   // select must lead the first clock edge by more than the setup time
   property p_cs_setup;
      $fell(host_port_select_n) |-> !sck [*4];
   endproperty
   a_cs_setup: assert property (p_cs_setup) else $error("sck rose too soon after select");
   property p_host_rel;
      host_port_select_n [*3] |-> host_oe == 4'h0;
   endproperty
   a_host_rel: assert property (p_host_rel) else $error("host drives while deselected");
   property p_dev_rel;
      host_port_select_n [*6] |-> dev_oe == 4'h0;
   endproperty
   a_dev_rel: assert property (p_dev_rel) else $error("device drives after deselect");
   property p_no_fight;
      (host_oe & dev_oe) == 4'h0;
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("both ends drive a line");
   property p_dev_nibble;
      dev_oe == 4'h0 || dev_oe == 4'hf;
   endproperty
   a_dev_nibble: assert property (p_dev_nibble) else $error("device drives a partial nibble");
   // read data may only move while sck is low; the host samples it at the next falling edge
   property p_dev_change;
      (dev_oe != 4'h0 && $changed(dev_dq)) |-> !sck;
   endproperty
   a_dev_change: assert property (p_dev_change) else $error("read data moved with sck high");
   property p_host_change;
      (host_oe != 4'h0 && $changed(host_dq)) |-> !sck;
   endproperty
   a_host_change: assert property (p_host_change) else $error("host data moved with sck high");
   property p_sck_high;
      $rose(sck) |=> sck [*5] ##1 !sck;
   endproperty
   a_sck_high: assert property (p_sck_high) else $error("sck high time wrong");
endmodule : sqp_assertions
`default_nettype wire

// ### tb/serial_quad_host_port_writes_tb.sv
// bench joining host and device ends over the link
`timescale 1ns/10ps
`default_nettype none
module serial_quad_host_port_writes_tb;
   import sqp_pkg::*;
   localparam logic [7:0] WOPS [5] = '{OP_WRITE, OP_DUAL_DATA_WRITE, OP_QUAD_DATA_WRITE,
      OP_DUAL_ADDR_DATA_WRITE, OP_QUAD_ADDR_DATA_WRITE};
   localparam int AWS [5] = '{1, 1, 1, 2, 4};
   localparam int DWS [5] = '{1, 2, 4, 2, 4};
   logic clk_i, rstn_i, cmd_valid, cmd_ready, enter_quad, quad_mode, host_quad;
   logic wr, rd, rd_pop, rdata_valid, done;
   logic [7:0] cmd_op, pops;
   logic [15:0] cmd_addr;
   logic [31:0] cmd_wdata, rdata, wr_data, rd_data;
   logic [3:0] cmd_words;
   logic [11:0] wr_addr, rd_addr;
   logic [3:0] smp [0:127];
   int ec, err_count, checks_done, cyc;
   logic [11:0] wq [$];
   logic [31:0] dq [$];
   logic [31:0] rq [$];
   sqp_if link ();
   sqp_host i_sqp_host (.clk_i(clk_i), .rstn_i(rstn_i), .link(link), .cmd_valid_i(cmd_valid),
      .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
      .cmd_words_i(cmd_words), .quad_mode_i(host_quad), .rdata_o(rdata),
      .rdata_valid_o(rdata_valid), .done_o(done));
   sqp_dev i_sqp_dev (.clk_i(clk_i), .rstn_i(rstn_i), .link(link), .enter_quad_i(enter_quad),
      .quad_mode_o(quad_mode), .wr_o(wr), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_o(rd),
      .rd_pop_o(rd_pop), .rd_addr_o(rd_addr), .rd_data_i(rd_data));
   sqp_assertions i_sqp_assertions (.clk_i(clk_i), .rstn_i(rstn_i), .sck(link.sck),
      .host_port_select_n(link.host_port_select_n), .host_dq(link.host_dq),
      .host_oe(link.host_oe), .dev_dq(link.dev_dq), .dev_oe(link.dev_oe));
   // register side: each word names its address and the pop count seen when fetched
   assign rd_data = {8'h5a, pops, 4'h0, rd_addr};
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (rd === 1'b1 && rd_pop === 1'b1)
         pops <= pops + 8'h01;
      if (wr === 1'b1)
      begin
         wq.push_back(wr_addr);
         dq.push_back(wr_data);
      end
      if (rdata_valid === 1'b1)
         rq.push_back(rdata);
      if (cyc == 60000)
      begin
         err_count++;
         conclude();
      end
   end
   // wire sampler: line levels at each rising sck edge of a frame
   always @(negedge link.host_port_select_n)
      ec = 0;
   always @(posedge link.sck)
      if (link.host_port_select_n === 1'b0 && ec < 128)
      begin
         smp[ec] = link.host_data_lines;
         ec++;
      end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic send(input logic [7:0] op, input logic [15:0] ad, input logic [31:0] d,
      input logic [3:0] n, input logic q);
      int t;
      @(negedge clk_i);
      cmd_op = op;
      cmd_addr = ad;
      cmd_wdata = d;
      cmd_words = n;
      host_quad = q;
      cmd_valid = 1'b1;
      t = 0;
      while (cmd_ready !== 1'b1 && t < 200)
      begin
         @(negedge clk_i);
         t++;
      end
      @(negedge clk_i);
      cmd_valid = 1'b0;
      t = 0;
      while (done !== 1'b1 && t < 5000)
      begin
         @(negedge clk_i);
         t++;
      end
      chk(32'(done), 32'h1);
      repeat (8) @(negedge clk_i);
   endtask : send
   task automatic t_writes();
      logic [15:0] ad;
      logic [31:0] d;
      logic [11:0] ea;
      for (int i = 0; i < 5; i++)
      begin
         ad = {2'(i % 3 + 1), 14'h0100 + 14'(i * 16)};
         d = 32'h8c3a5e71 + 32'(i * 32'h01010101);
         send(WOPS[i], ad, d, 4'h3, 1'b0);
         for (int b = 0; b < 8; b++)
            chk(32'(smp[b][0]), 32'(WOPS[i][7 - b]));
         chk(32'(smp[8]) & ((32'h1 << AWS[i]) - 1), 32'(ad >> (16 - AWS[i])));
         chk(32'(smp[8 + 16 / AWS[i]]) & ((32'h1 << DWS[i]) - 1), 32'(d[7:0] >> (8 - DWS[i])));
         chk(32'(wq.size()), 32'h3);
         for (int k = 0; k < 3; k++)
         begin
            ea = ad[13:2];
            if (ad[15:14] == 2'h1)
               ea = ea + 12'(k);
            if (ad[15:14] == 2'h2)
               ea = ea - 12'(k);
            chk(32'(wq.pop_front()), 32'(ea));
            chk(dq.pop_front(), d);
         end
      end
   endtask : t_writes
   task automatic t_read();
      send(OP_QUAD_IO_READ, 16'h0040, 32'h0, 4'h2, 1'b0);
      chk(32'(smp[20]), 32'h1);
      chk(32'(rq.size()), 32'h2);
      chk(rq.pop_front(), 32'h5a000010);
      chk(rq.pop_front(), 32'h5a010010);
      send(OP_QUAD_IO_READ, 16'h4048, 32'h0, 4'h2, 1'b0);
      chk(rq.pop_front(), 32'h5a020012);
      chk(rq.pop_front(), 32'h5a020013);
   endtask : t_read
   task automatic t_quad();
      @(negedge clk_i);
      enter_quad = 1'b1;
      @(negedge clk_i);
      enter_quad = 1'b0;
      repeat (2) @(negedge clk_i);
      chk(32'(quad_mode), 32'h1);
      send(OP_WRITE, 16'h4200, 32'hc3a50f96, 4'h1, 1'b1);
      chk(32'(smp[1]), 32'h2);
      chk(32'(smp[6]), 32'h9);
      chk(32'(wq.pop_front()), 32'h080);
      chk(dq.pop_front(), 32'hc3a50f96);
      // multi-line codes and the quad read, sent nibble-wide, must all be ignored in this mode
      for (int i = 1; i < 5; i++)
         send(WOPS[i], 16'h4200, 32'h0f0f0f0f, 4'h1, 1'b1);
      send(OP_QUAD_IO_READ, 16'h0040, 32'h0, 4'h1, 1'b1);
      chk(32'(wq.size()), 32'h0);
      chk(32'(pops), 32'h2);
      send(OP_LEAVE_QUAD_MODE, 16'h0, 32'h0, 4'h1, 1'b1);
      chk(32'(quad_mode), 32'h0);
      // nibble-wide frame read serially decodes as a write cut six bits into its data
      send(OP_WRITE, 16'h4200, 32'h00000012, 4'h3, 1'b1);
      chk(32'(wq.size()), 32'h0);
      send(8'h5a, 16'h4200, 32'h11223344, 4'h1, 1'b0);
      chk(32'(wq.size()), 32'h0);
      chk(32'(link.dev_oe), 32'h0);
   endtask : t_quad
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude
   initial
   begin
      rstn_i = 1'b0;
      cmd_valid = 1'b0;
      enter_quad = 1'b0;
      host_quad = 1'b0;
      cmd_op = 8'h00;
      cmd_addr = 16'h0000;
      cmd_wdata = 32'h0;
      cmd_words = 4'h1;
      pops = 8'h00;
      cyc = 0;
      ec = 0;
      err_count = 0;
      checks_done = 0;
      repeat (16) @(negedge clk_i);
      rstn_i = 1'b1;
      t_writes();
      t_read();
      t_quad();
      conclude();
   end
endmodule : serial_quad_host_port_writes_tb
`default_nettype wire
